// File: logic/bts_sequencer.sv
// Breaker trip/close test sequencer with Avalon-MM registers and interrupt.
// Assumes breaker inputs and protection pickup are synchronous to i_clock.
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module bts_sequencer (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [bts_pkg::BTS_ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output logic [1:0] o_response,
    input wire logic i_breaker_closed,
    input wire logic i_breaker_ready,
    input wire logic i_prot_pickup,
    input wire logic i_system_fault,
    output logic [2:0] o_test_trip_cmd,
    output logic o_test_close_cmd,
    output logic o_test_in_progress_flag,
    output logic o_refused_system_fault,
    output logic o_refused_breaker_open,
    output logic o_refused_not_ready,
    output logic o_aborted_still_closed,
    output logic o_test_success_flag,
    output logic o_irq
);
    import bts_pkg::*;

    typedef enum logic [2:0] {
        BTS_IDLE,
        BTS_TRIP,
        BTS_SETTLE,
        BTS_CLOSE
    } bts_state_e;

    // ------------------------------------------------------------------
    // Registers and bus
    // ------------------------------------------------------------------
    logic [31:0] cfg_ff;
    logic [31:0] trip_time_ff;
    logic [31:0] close_time_ff;
    logic [BTS_EV_W-1:0] irq_stat_ff;
    logic [BTS_EV_W-1:0] irq_en_ff;
    logic [BTS_EV_W-1:0] events;
    logic [31:0] readdata_ff;
    logic ack_ff;
    logic [1:0] response_ff;
    bts_state_e state_ff;
    logic [1:0] prog_ff;
    logic [2:0] trip_ff;
    logic close_ff;
    logic [5:0] ind_ff;
    logic timer_load;
    logic [31:0] timer_count;
    logic timer_done;
    logic access;
    logic wr_stb;
    logic start_req;
    logic [1:0] req_prog;
    logic req_confirm;
    logic closed_ok;
    logic sp_allowed;
    logic prog_ok;
    logic addr_ok;

    function automatic logic [2:0] bts_pole_mask(input logic [1:0] prog);
        unique case (prog)
            BTS_PROG_L1: bts_pole_mask = 3'h1;
            BTS_PROG_L2: bts_pole_mask = 3'h2;
            BTS_PROG_L3: bts_pole_mask = 3'h4;
            BTS_PROG_L123: bts_pole_mask = 3'h7;
        endcase
    endfunction : bts_pole_mask

    // One wait cycle per access. Writes land only at the edge where waitrequest is low,
    // so a master that drops a request early never leaves a half-done write behind.
    assign access = (i_read || i_write) && !ack_ff;
    assign o_waitrequest = (i_read || i_write) && !ack_ff;
    assign wr_stb = i_write && ack_ff;
    assign addr_ok = (i_address[1:0] == 2'h0) && (i_address <= BTS_REG_IRQ_EN);

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= access;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            readdata_ff <= 32'h0000_0000;
            response_ff <= 2'h0;
        end else if (access) begin
            response_ff <= addr_ok ? 2'h0 : 2'h3;
            readdata_ff <= 32'h0000_0000;
            if (i_read) begin
                unique case (i_address)
                    BTS_ADDR_W'(BTS_REG_CFG): readdata_ff <= cfg_ff;
                    BTS_ADDR_W'(BTS_REG_TRIP_TIME): readdata_ff <= trip_time_ff;
                    BTS_ADDR_W'(BTS_REG_CLOSE_TIME): readdata_ff <= close_time_ff;
                    BTS_REG_STATUS: readdata_ff <= {23'h0, (state_ff != BTS_IDLE),
                                                    2'h0, ind_ff};
                    BTS_REG_IRQ_STAT: readdata_ff <= {26'h0, irq_stat_ff};
                    BTS_REG_IRQ_EN: readdata_ff <= {26'h0, irq_en_ff};
                    default: readdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign o_readdata = readdata_ff;
    assign o_response = response_ff;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_ff <= BTS_CFG_RESET | {16'h0, BTS_SETTLE_RESET, 8'h0};
            trip_time_ff <= BTS_TRIP_CYC_RESET;
            close_time_ff <= BTS_CLOSE_CYC_RESET;
            irq_en_ff <= '0;
        end else if (wr_stb) begin
            unique case (i_address)
                BTS_ADDR_W'(BTS_REG_CFG): cfg_ff <= i_writedata;
                BTS_ADDR_W'(BTS_REG_TRIP_TIME): trip_time_ff <= i_writedata;
                BTS_ADDR_W'(BTS_REG_CLOSE_TIME): close_time_ff <= i_writedata;
                BTS_REG_IRQ_EN: irq_en_ff <= i_writedata[BTS_EV_W-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Start checks
    // ------------------------------------------------------------------
    assign start_req = wr_stb && (i_address == BTS_ADDR_W'(BTS_REG_CTRL))
                       && i_writedata[BTS_CTRL_START];
    assign req_prog = i_writedata[BTS_CTRL_PROG_LSB +: 2];
    // The operator selects the program and confirms the closed breaker in CTRL.
    assign req_confirm = i_writedata[BTS_CTRL_CONFIRM];
    // Aux contacts override the operator's answer when they are configured.
    assign closed_ok = cfg_ff[BTS_CFG_AUX_EN] ? i_breaker_closed
                                              : req_confirm;
    assign sp_allowed = cfg_ff[BTS_CFG_SP_DEV] && cfg_ff[BTS_CFG_SP_CB];
    // Without single-pole support only program four is offered.
    assign prog_ok = (req_prog == BTS_PROG_L123) || sp_allowed;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        timer_load = 1'b0;
        timer_count = trip_time_ff;
        unique case (state_ff)
            BTS_IDLE: begin
                timer_load = start_req && prog_ok && !i_system_fault && !i_prot_pickup
                             && closed_ok && i_breaker_ready;
                timer_count = trip_time_ff;
            end
            BTS_TRIP: begin
                timer_load = timer_done;
                timer_count = {24'h0, cfg_ff[BTS_CFG_SETTLE_LSB +: 8]};
            end
            BTS_SETTLE: begin
                timer_load = timer_done && !i_breaker_closed;
                timer_count = close_time_ff;
            end
            BTS_CLOSE: begin
                timer_load = 1'b0;
                timer_count = close_time_ff;
            end
            default: ;
        endcase
    end

    bts_timer #(
        .WIDTH(32)
    ) u_timer (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_load(timer_load),
        .i_count(timer_count),
        .o_done(timer_done)
    );

    // Indications stay until the next accepted or refused start, so software can read them.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= BTS_IDLE;
            prog_ff <= 2'h0;
            trip_ff <= 3'h0;
            close_ff <= 1'b0;
            ind_ff <= 6'h0;
        end else begin
            unique case (state_ff)
                BTS_IDLE: begin
                    if (start_req) begin
                        ind_ff <= 6'h0;
                        if (!prog_ok) begin
                            ind_ff[BTS_EV_REF_PROG] <= 1'b1;
                        end else if (i_system_fault || i_prot_pickup) begin
                            ind_ff[BTS_EV_REF_FAULT] <= 1'b1;
                        end else if (!closed_ok) begin
                            ind_ff[BTS_EV_REF_OPEN] <= 1'b1;
                        end else if (!i_breaker_ready) begin
                            ind_ff[BTS_EV_REF_NOT_READY] <= 1'b1;
                        end else begin
                            prog_ff <= req_prog;
                            trip_ff <= bts_pole_mask(req_prog);
                            state_ff <= BTS_TRIP;
                        end
                    end
                end
                BTS_TRIP: begin
                    if (timer_done) begin
                        trip_ff <= 3'h0;
                        state_ff <= BTS_SETTLE;
                    end
                end
                BTS_SETTLE: begin
                    if (timer_done) begin
                        if (i_breaker_closed) begin
                            ind_ff[BTS_EV_ABORT_CLOSED] <= 1'b1;
                            state_ff <= BTS_IDLE;
                        end else begin
                            close_ff <= 1'b1;
                            state_ff <= BTS_CLOSE;
                        end
                    end
                end
                BTS_CLOSE: begin
                    if (timer_done) begin
                        close_ff <= 1'b0;
                        ind_ff[BTS_EV_SUCCESS] <= 1'b1;
                        state_ff <= BTS_IDLE;
                    end
                end
                default: state_ff <= BTS_IDLE;
            endcase
        end
    end

    assign o_test_trip_cmd = trip_ff;
    assign o_test_close_cmd = close_ff;
    assign o_test_in_progress_flag = (state_ff != BTS_IDLE);
    assign o_refused_system_fault = ind_ff[BTS_EV_REF_FAULT];
    assign o_refused_breaker_open = ind_ff[BTS_EV_REF_OPEN];
    assign o_refused_not_ready = ind_ff[BTS_EV_REF_NOT_READY];
    assign o_aborted_still_closed = ind_ff[BTS_EV_ABORT_CLOSED];
    assign o_test_success_flag = ind_ff[BTS_EV_SUCCESS];

    // ------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------
    // Rising indication bits are the events; a set in the clearing cycle wins.
    logic [BTS_EV_W-1:0] ind_prev_ff;
    logic [BTS_EV_W-1:0] clr_mask;

    assign events = ind_ff & ~ind_prev_ff;
    assign clr_mask = (wr_stb && (i_address == BTS_REG_IRQ_CLR))
                      ? i_writedata[BTS_EV_W-1:0] : '0;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ind_prev_ff <= '0;
            irq_stat_ff <= '0;
        end else begin
            ind_prev_ff <= ind_ff;
            irq_stat_ff <= (irq_stat_ff & ~clr_mask) | events;
        end
    end

    assign o_irq = |(irq_stat_ff & irq_en_ff);

endmodule : bts_sequencer

// File: logic/bts_pkg.sv
// Constants, register map and indication layout of the breaker test sequencer.
// Assumes one 200 MHz clock and an Avalon-MM register slave in the main module.
// Notes on behaviour
// - At most four test programs; start accepted only for a configured one.
// - Programs one to three trip only L1, L2 or L3, then close.
// - Three-pole-only configuration allows program four alone, tripping all poles.
// - A cycle is a trip command followed by the associated close command.
// - Single-pole programs need single-pole device support and single-pole breaker wiring.
// - With position feedback configured, start only while feedback reports closed.
// - Refuse start while any protection function is picked up.
// - Refuse start unless breaker-ready input is asserted.
// - Test-in-progress indication held for the whole cycle, dropped at its end.
// - Refusal for system fault or pickup raises the fault-refusal indication.
// - Refusal for breaker not closed raises the breaker-open indication.
// - Refusal for breaker not ready raises the not-ready indication.
// - Breaker still closed after trip: abort without closing, raise still-closed abort.
// - A cycle ending without refusal or abort raises test-successful.
// - Configured auxiliary contacts reporting open refuse even with operator confirmation.
// - Without auxiliary contacts, operator confirmation stands for breaker closed.
package bts_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] BTS_REG_CTRL = 4'h0;
    localparam logic [3:0] BTS_REG_CFG = 4'h4;
    localparam logic [3:0] BTS_REG_TRIP_TIME = 4'h8;
    localparam logic [3:0] BTS_REG_CLOSE_TIME = 4'hC;
    localparam logic [4:0] BTS_REG_STATUS = 5'h10;
    localparam logic [4:0] BTS_REG_IRQ_STAT = 5'h14;
    localparam logic [4:0] BTS_REG_IRQ_CLR = 5'h18;
    localparam logic [4:0] BTS_REG_IRQ_EN = 5'h1C;
    localparam int BTS_ADDR_W = 5;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // CTRL: write 1 to START with PROG in bits 2:1 and CONFIRM in bit 3.
    localparam int BTS_CTRL_START = 0;
    localparam int BTS_CTRL_PROG_LSB = 1;
    localparam int BTS_CTRL_CONFIRM = 3;
    // CFG.
    localparam int BTS_CFG_AUX_EN = 0;
    localparam int BTS_CFG_SP_DEV = 1;
    localparam int BTS_CFG_SP_CB = 2;
    localparam int BTS_CFG_SETTLE_LSB = 8;
    // Event bits, shared by STATUS low bits and the interrupt registers.
    localparam int BTS_EV_REF_FAULT = 0;
    localparam int BTS_EV_REF_OPEN = 1;
    localparam int BTS_EV_REF_NOT_READY = 2;
    localparam int BTS_EV_ABORT_CLOSED = 3;
    localparam int BTS_EV_SUCCESS = 4;
    localparam int BTS_EV_REF_PROG = 5;
    localparam int BTS_EV_W = 6;
    localparam int BTS_ST_BUSY = 8;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [31:0] BTS_CFG_RESET = 32'h0000_0000;
    localparam int BTS_CLK_MHZ = 200;
    localparam int BTS_TRIP_MS = 100;
    localparam int BTS_CLOSE_MS = 100;
    localparam logic [31:0] BTS_TRIP_CYC_RESET = 32'(BTS_TRIP_MS * 1000 * BTS_CLK_MHZ);
    localparam logic [31:0] BTS_CLOSE_CYC_RESET = 32'(BTS_CLOSE_MS * 1000 * BTS_CLK_MHZ);
    localparam logic [7:0] BTS_SETTLE_RESET = 8'h10;

    typedef enum logic [1:0] {
        BTS_PROG_L1,
        BTS_PROG_L2,
        BTS_PROG_L3,
        BTS_PROG_L123
    } bts_prog_e;

endpackage : bts_pkg

// File: logic/bts_timer.sv
// Down-counting pulse timer used for the trip, gap and close phases.
// Assumes the caller loads it once per phase and waits for o_done.
`timescale 1ns/1ps
module bts_timer #(
    parameter int WIDTH = 32
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_count,
    output logic o_done
);
    logic [WIDTH-1:0] count_ff;
    logic running_ff;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            count_ff <= '0;
            running_ff <= 1'b0;
        end else if (i_load) begin
            // A zero count still gives one cycle of pulse.
            count_ff <= (i_count == '0) ? WIDTH'(1) : i_count;
            running_ff <= 1'b1;
        end else if (running_ff) begin
            count_ff <= count_ff - WIDTH'(1);
            if (count_ff == WIDTH'(1)) begin
                running_ff <= 1'b0;
            end
        end
    end

    assign o_done = running_ff && (count_ff == WIDTH'(1));

endmodule : bts_timer

// File: dv/bts_sequencer_props.sv
// Port-level checker for the breaker test sequencer.
// Assumes it is bound to bts_sequencer and sees only that module's ports.
`timescale 1ns/1ps
module bts_sequencer_props (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic o_waitrequest,
    input wire logic [2:0] o_test_trip_cmd,
    input wire logic o_test_close_cmd,
    input wire logic o_test_in_progress_flag,
    input wire logic o_refused_system_fault,
    input wire logic o_refused_breaker_open,
    input wire logic o_refused_not_ready,
    input wire logic o_aborted_still_closed,
    input wire logic o_test_success_flag
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    a_wait_one: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("bus request held more than one wait cycle");
    a_trip_close_excl: assert property (!((o_test_trip_cmd != 3'h0) && o_test_close_cmd))
        else $error("trip and close commands overlap");
    a_trip_busy: assert property ((o_test_trip_cmd != 3'h0) |-> o_test_in_progress_flag)
        else $error("trip issued outside a running test");
    a_close_busy: assert property (o_test_close_cmd |-> o_test_in_progress_flag)
        else $error("close issued outside a running test");
    a_trip_mask: assert property (o_test_trip_cmd inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h7})
        else $error("illegal pole mask on trip command");
    a_start_trip: assert property (
        $rose(o_test_in_progress_flag) |-> ##[0:2] (o_test_trip_cmd != 3'h0))
        else $error("test started without a trip command");
    a_abort_noclose: assert property (
        o_aborted_still_closed |-> !o_test_close_cmd && !o_test_success_flag)
        else $error("close or success after still-closed abort");
    a_success_idle: assert property (o_test_success_flag |-> !o_test_in_progress_flag)
        else $error("success shown while test runs");
    a_refuse_idle: assert property (
        (o_refused_system_fault || o_refused_breaker_open || o_refused_not_ready)
        |-> !o_test_in_progress_flag && o_test_trip_cmd == 3'h0)
        else $error("refused test still running");

    c_success: cover property ($rose(o_test_success_flag));
    c_abort: cover property ($rose(o_aborted_still_closed));
    c_refuse_open: cover property ($rose(o_refused_breaker_open));
endmodule : bts_sequencer_props

bind bts_sequencer bts_sequencer_props u_props (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_read(i_read), .i_write(i_write), .o_waitrequest(o_waitrequest),
    .o_test_trip_cmd(o_test_trip_cmd), .o_test_close_cmd(o_test_close_cmd),
    .o_test_in_progress_flag(o_test_in_progress_flag),
    .o_refused_system_fault(o_refused_system_fault),
    .o_refused_breaker_open(o_refused_breaker_open), .o_refused_not_ready(o_refused_not_ready),
    .o_aborted_still_closed(o_aborted_still_closed), .o_test_success_flag(o_test_success_flag));

// File: dv/bts_breaker_model.sv
// Behavioural circuit breaker with one auxiliary contact for all poles.
// Assumes trip and close arrive as levels; a stuck breaker ignores trip.
`timescale 1ns/1ps
module bts_breaker_model (
    input wire logic i_clock,
    input wire logic [2:0] i_trip,
    input wire logic i_close,
    input wire logic i_stuck,
    input wire logic i_open,
    output logic o_closed
);
    logic closed_ff = 1'b1;

    assign o_closed = closed_ff;

    // ------------------------------------------------------------------
    // Contact state
    // ------------------------------------------------------------------
    // Any opened pole breaks the series contact, so single-pole trips show open too.
    always @(posedge i_clock) begin
        if (i_close) begin
            closed_ff <= 1'b1;
        end else if (i_open || (i_trip != 3'h0 && !i_stuck)) begin
            closed_ff <= 1'b0;
        end
    end
endmodule : bts_breaker_model

// File: dv/testbench.sv
// Self-checking bench for the breaker test sequencer.
// Assumes the breaker model answers commands and the bench plays the operator.
`timescale 1ns/1ps
module testbench;
    import bts_pkg::*;
    localparam logic [31:0] TRIP_CYC = 32'h4;
    localparam logic [31:0] CLOSE_CYC = 32'h5;
    logic clock = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0, waitreq, irq;
    logic [4:0] address = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, rdat, trip_cnt, close_cnt;
    logic [1:0] resp, rsp;
    logic closed, ready = 1'b1, pickup = 1'b0, fault = 1'b0, stuck = 1'b0, brk_open = 1'b0;
    logic [2:0] trip, trip_seen;
    logic close, busy, r_fault, r_open, r_nr, abort, ok;
    int fails = 0, num_checks = 0;

    always #2.5 clock = ~clock;

    bts_sequencer dut (.i_clock(clock), .i_resetn(resetn), .i_address(address), .i_read(rd),
        .i_write(wr), .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(waitreq),
        .o_response(resp), .i_breaker_closed(closed), .i_breaker_ready(ready),
        .i_prot_pickup(pickup), .i_system_fault(fault), .o_test_trip_cmd(trip),
        .o_test_close_cmd(close), .o_test_in_progress_flag(busy), .o_refused_system_fault(r_fault),
        .o_refused_breaker_open(r_open), .o_refused_not_ready(r_nr),
        .o_aborted_still_closed(abort), .o_test_success_flag(ok), .o_irq(irq));
    bts_breaker_model u_breaker (.i_clock(clock), .i_trip(trip), .i_close(close),
        .i_stuck(stuck), .i_open(brk_open), .o_closed(closed));

    always @(posedge clock) begin
        if (trip !== 3'h0) trip_cnt = trip_cnt + 1;
        if (close === 1'b1) close_cnt = close_cnt + 1;
        trip_seen = trip_seen | trip;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        rd <= !w;
        wr <= w;
        address <= a;
        wdata <= d;
        // Only the watchdog ends a wait that never gets its answer.
        do begin
            @(posedge clock);
        end while (waitreq !== 1'b0);
        rdat = rdata;
        rsp = resp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    // A second start during the run must leave no trace in the outcome.
    task automatic run(input logic [3:0] ctrl, input logic [5:0] exp, input logic [2:0] mask,
                       input bit again);
        int n;
        n = 0;
        trip_cnt = 32'h0;
        close_cnt = 32'h0;
        trip_seen = 3'h0;
        bus(1'b1, 5'(BTS_REG_CTRL), {28'h0, ctrl});
        if (again) bus(1'b1, 5'(BTS_REG_CTRL), 32'h1);
        repeat (2) @(posedge clock);
        while (busy === 1'b1 && n < 500) begin
            @(posedge clock);
            n++;
        end
        if (n >= 500) fails++;
        bus(1'b0, BTS_REG_STATUS, 32'h0);
        chk("status", rdat, {26'h0, exp});
        chk("flags", {27'h0, ok, abort, r_nr, r_open, r_fault}, {27'h0, exp[4:0]});
        chk("trip mask", {29'h0, trip_seen}, {29'h0, mask});
        chk("trip cycles", trip_cnt, (mask != 3'h0) ? TRIP_CYC : 32'h0);
        chk("close cycles", close_cnt, exp[4] ? CLOSE_CYC : 32'h0);
        $display("test with control %h done", ctrl);
    endtask : run

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        bus(1'b0, 5'(BTS_REG_TRIP_TIME), 32'h0);
        chk("trip time reset", rdat, BTS_TRIP_CYC_RESET);
        bus(1'b0, 5'h06, 32'h0);
        chk("unmapped data", rdat, 32'h0);
        chk("unmapped resp", {30'h0, rsp}, 32'h3);
        bus(1'b1, 5'(BTS_REG_TRIP_TIME), TRIP_CYC);
        bus(1'b1, 5'(BTS_REG_CLOSE_TIME), CLOSE_CYC);
        bus(1'b1, 5'(BTS_REG_CFG), 32'h0000_0201);
        run(4'h7, 6'h10, 3'h7, 1'b1);
        bus(1'b0, BTS_REG_IRQ_STAT, 32'h0);
        chk("irq status", rdat, 32'h10);
        chk("irq masked", {31'h0, irq}, 32'h0);
        bus(1'b1, BTS_REG_IRQ_EN, 32'h3F);
        @(posedge clock);
        chk("irq raised", {31'h0, irq}, 32'h1);
        bus(1'b1, BTS_REG_IRQ_CLR, 32'h3F);
        @(posedge clock);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        run(4'h1, 6'h20, 3'h0, 1'b0);
        bus(1'b1, 5'(BTS_REG_CFG), 32'h0000_0203);
        run(4'h1, 6'h20, 3'h0, 1'b0);
        bus(1'b1, 5'(BTS_REG_CFG), 32'h0000_0207);
        for (int p = 0; p < 3; p++) run({1'b0, 2'(p), 1'b1}, 6'h10, 3'(1 << p), 1'b0);
        pickup <= 1'b1;
        run(4'h7, 6'h01, 3'h0, 1'b0);
        pickup <= 1'b0;
        fault <= 1'b1;
        run(4'h7, 6'h01, 3'h0, 1'b0);
        fault <= 1'b0;
        ready <= 1'b0;
        run(4'h7, 6'h04, 3'h0, 1'b0);
        ready <= 1'b1;
        stuck <= 1'b1;
        run(4'h7, 6'h08, 3'h7, 1'b0);
        stuck <= 1'b0;
        brk_open <= 1'b1;
        @(posedge clock);
        brk_open <= 1'b0;
        run(4'hF, 6'h02, 3'h0, 1'b0);
        bus(1'b1, 5'(BTS_REG_CFG), 32'h0000_0200);
        run(4'h7, 6'h02, 3'h0, 1'b0);
        run(4'hF, 6'h10, 3'h7, 1'b0);
        summarize();
    end

    // The whole sequence needs well under 2000 cycles.
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        summarize();
    end
endmodule : testbench
